/* File: logic/queue_ctrl_pkg.sv */
// shared constants for the command stream queue control block
package queue_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_MISC_INIT = 4'h0;
    localparam logic [3:0] OFF_BASE_END = 4'h1;
    localparam logic [3:0] OFF_BUMP = 4'h2;
    localparam logic [3:0] OFF_RD_PTR = 4'h3;
    localparam logic [3:0] OFF_MIN_ADDR = 4'h4;
    localparam logic [3:0] OFF_MAX_ADDR = 4'h5;
    localparam logic [3:0] OFF_DEPTH = 4'h6;
    localparam logic [3:0] OFF_HOLES = 4'h7;
    localparam logic [3:0] OFF_CMD = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'h9;
    localparam int STRAP_LSB = 0;
    localparam int STRAP_MSB = 7;
    localparam int QUEUE_EN_BIT = 8;
    localparam int OFFSCREEN_BIT = 9;
    localparam int NO_HOLE_CNT_BIT = 10;
    localparam int FETCH_THR_LSB = 11;
    localparam int FETCH_THR_MSB = 15;
    localparam int SYNC_WR_BIT = 16;
    localparam int SYNC_RD_BIT = 17;
    localparam int PACKER_RST_BIT = 18;
    localparam int KEY_FWD_BIT = 19;
    localparam int TIMEOUT_LSB = 20;
    localparam int TIMEOUT_MSB = 26;
    localparam int TEX_BURST_BIT = 27;
    localparam logic [31:0] MISC_WR_MASK = 32'h0FFF_FF00;
    localparam int BASE_LSB = 0;
    localparam int BASE_MSB = 9;
    localparam int END_LSB = 16;
    localparam int END_MSB = 25;
    localparam logic [31:0] BASE_END_MASK = 32'h03FF_03FF;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [15:0] RESET_HALF = 16'h0000;
    localparam logic [1:0] CMD_FETCH = 2'h1;
    localparam logic [1:0] CMD_HOLE = 2'h2;
    localparam logic [1:0] CMD_PRIMARY_MEM_Q = 2'h3;
endpackage : queue_ctrl_pkg

/* File: logic/queue_ctrl_if.sv */
// register port between host end and queue control end
`timescale 1ns/10ps
`default_nettype none
interface queue_ctrl_if;
    logic [queue_ctrl_pkg::ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [31:0] rdata;
    logic unlock;
    modport host (output addr, output wdata, output wr_stb, output rd_stb, output unlock, input rdata);
    modport device (input addr, input wdata, input wr_stb, input rd_stb, input unlock, output rdata);
endinterface : queue_ctrl_if
`default_nettype wire

/* File: logic/queue_ctrl_device.sv */
// command stream queue control and status registers
// Function
// - init writes dropped unless unlock bit set
// - init writes apply immediately, not queued
// - host takes care with out-of-order init writes
// - host issues single-cycle writes only
// - bits 7:0 capture strap lines at reset
// - queue enable excludes memory queue enable
// - bit 9 selects internal or offscreen store
// - bit 10 disables automatic hole counting
// - bits 15:11 hold fetch threshold
// - bits 16,17 synchronise writes and reads
// - bit 18 holds data packer in reset
// - bit 19 forwards color key writes
// - bits 26:20 hold timeout count
// - bit 27 enables texture link bursts
// - base register holds start and end pages
// - bump register shows 16-bit bump count
// - read pointer register is 32 bits
// - min and max address registers, 32 bits
// - holes register shows 16-bit hole count
// - depth register shows pending entry count
`timescale 1ns/10ps
`default_nettype none
module queue_ctrl_device (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    queue_ctrl_if.device bus,
    input wire logic [7:0] frame_memory_data_lines_i,
    input wire logic primary_mem_queue_en_i,
    input wire logic color_key_wr_i,
    input wire logic fetch_take_i,
    input wire logic hole_fill_i,
    output logic queue_en_o,
    output logic offscreen_o,
    output logic [4:0] fetch_thr_o,
    output logic sync_wr_o,
    output logic sync_rd_o,
    output logic packer_rst_o,
    output logic key_fwd_o,
    output logic [6:0] timeout_o,
    output logic tex_burst_o,
    output logic fetch_ok_o
);
    typedef struct packed {
        logic [2:0] strap_sync;
        logic [7:0] strap_s1;
        logic [7:0] strap_s2;
        logic [31:0] misc;
        logic [31:0] base_end;
        logic [15:0] bump;
        logic [31:0] rd_ptr;
        logic [31:0] amin;
        logic [31:0] amax;
        logic [31:0] depth;
        logic [15:0] holes;
        logic [31:0] rdata;
        logic fetch_ok;
        logic key_fwd;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    // step the read pointer one word, back to the lower bound once past the upper one
    function automatic logic [31:0] next_rd_ptr(input logic [31:0] p, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] step;
        step = p + 32'h0000_0004;
        if (step > hi) begin
            next_rd_ptr = lo;
        end else begin
            next_rd_ptr = step;
        end
    endfunction : next_rd_ptr

    // pending entries: a filled hole adds one, a taken entry removes one, both at once cancel
    function automatic logic [31:0] next_depth(input logic [31:0] d, input logic add, input logic sub);
        next_depth = d;
        if (add && !sub) begin
            next_depth = d + 32'h0000_0001;
        end else if (sub && !add) begin
            next_depth = d - 32'h0000_0001;
        end
    endfunction : next_depth

    // read multiplexer; unmapped offsets read as zero, narrow registers zero-extend
    function automatic logic [31:0] read_word(input logic [3:0] a, input state_s s);
        read_word = 32'h0000_0000;
        if (hit(a, queue_ctrl_pkg::OFF_MISC_INIT)) begin
            read_word = s.misc;
        end else if (hit(a, queue_ctrl_pkg::OFF_BASE_END)) begin
            read_word = s.base_end;
        end else if (hit(a, queue_ctrl_pkg::OFF_BUMP)) begin
            read_word = {16'h0000, s.bump};
        end else if (hit(a, queue_ctrl_pkg::OFF_RD_PTR)) begin
            read_word = s.rd_ptr;
        end else if (hit(a, queue_ctrl_pkg::OFF_MIN_ADDR)) begin
            read_word = s.amin;
        end else if (hit(a, queue_ctrl_pkg::OFF_MAX_ADDR)) begin
            read_word = s.amax;
        end else if (hit(a, queue_ctrl_pkg::OFF_DEPTH)) begin
            read_word = s.depth;
        end else if (hit(a, queue_ctrl_pkg::OFF_HOLES)) begin
            read_word = {16'h0000, s.holes};
        end
    endfunction : read_word

    logic wr_misc;
    logic [31:0] misc_new;
    logic auto_holes;
    logic hole_add;
    logic take_ok;

    always_comb begin
        st_nxt = st_r;

        // init word write: locked writes are dropped, straps and reserved bits are kept
        wr_misc = bus.wr_stb && hit(bus.addr, queue_ctrl_pkg::OFF_MISC_INIT) && bus.unlock;
        misc_new = (bus.wdata & queue_ctrl_pkg::MISC_WR_MASK) | {24'h000000, st_r.misc[7:0]};
        // memory queue enable has priority; queue enable cannot coexist
        if (primary_mem_queue_en_i) begin
            misc_new[queue_ctrl_pkg::QUEUE_EN_BIT] = 1'b0;
        end
        auto_holes = !st_r.misc[queue_ctrl_pkg::NO_HOLE_CNT_BIT];
        if (wr_misc) begin
            st_nxt.misc = misc_new;
        end
        if (primary_mem_queue_en_i) begin
            st_nxt.misc[queue_ctrl_pkg::QUEUE_EN_BIT] = 1'b0;
        end

        // strap capture: two flops, then one load once the second flop holds the pin levels
        st_nxt.strap_s1 = frame_memory_data_lines_i;
        st_nxt.strap_s2 = st_r.strap_s1;
        st_nxt.strap_sync = {st_r.strap_sync[1:0], 1'b1};
        // applied after the write so a write in the same cycle cannot drop the straps
        if (st_r.strap_sync == 3'b011) begin
            st_nxt.misc[queue_ctrl_pkg::STRAP_MSB:queue_ctrl_pkg::STRAP_LSB] = st_r.strap_s2;
        end

        // hole counting and fetch bookkeeping
        hole_add = auto_holes && hole_fill_i;
        take_ok = fetch_take_i && st_r.fetch_ok;
        if (st_r.misc[queue_ctrl_pkg::QUEUE_EN_BIT]) begin
            if (hole_add) begin
                st_nxt.holes = st_r.holes + 16'h0001;
            end
            if (take_ok) begin
                st_nxt.rd_ptr = next_rd_ptr(st_r.rd_ptr, st_r.amin, st_r.amax);
            end
            st_nxt.depth = next_depth(st_r.depth, hole_add, take_ok);
        end

        // register writes; depth is always host-loadable for manual bumping
        if (bus.wr_stb) begin
            if (hit(bus.addr, queue_ctrl_pkg::OFF_BASE_END)) begin
                st_nxt.base_end = bus.wdata & queue_ctrl_pkg::BASE_END_MASK;
            end else if (hit(bus.addr, queue_ctrl_pkg::OFF_BUMP)) begin
                st_nxt.bump = bus.wdata[15:0];
            end else if (hit(bus.addr, queue_ctrl_pkg::OFF_RD_PTR)) begin
                st_nxt.rd_ptr = bus.wdata;
            end else if (hit(bus.addr, queue_ctrl_pkg::OFF_MIN_ADDR)) begin
                st_nxt.amin = bus.wdata;
            end else if (hit(bus.addr, queue_ctrl_pkg::OFF_MAX_ADDR)) begin
                st_nxt.amax = bus.wdata;
            end else if (hit(bus.addr, queue_ctrl_pkg::OFF_DEPTH)) begin
                st_nxt.depth = bus.wdata;
            end else if (hit(bus.addr, queue_ctrl_pkg::OFF_HOLES)) begin
                st_nxt.holes = bus.wdata[15:0];
            end
        end

        // fetch gate and readback; rdata stands only in the cycle after the strobe
        st_nxt.fetch_ok = st_r.misc[queue_ctrl_pkg::QUEUE_EN_BIT] && (st_nxt.depth != 32'h0000_0000);
        st_nxt.rdata = 32'h0000_0000;
        if (bus.rd_stb) begin
            st_nxt.rdata = read_word(bus.addr, st_r);
        end
        st_nxt.key_fwd = st_r.misc[queue_ctrl_pkg::KEY_FWD_BIT] && color_key_wr_i;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    assign bus.rdata = st_r.rdata;
    // configuration outputs come straight from the init word flops, except key_fwd_o, a flop of bit 19 gated with color_key_wr_i
    assign queue_en_o = st_r.misc[queue_ctrl_pkg::QUEUE_EN_BIT];
    assign offscreen_o = st_r.misc[queue_ctrl_pkg::OFFSCREEN_BIT];
    assign fetch_thr_o = st_r.misc[queue_ctrl_pkg::FETCH_THR_MSB:queue_ctrl_pkg::FETCH_THR_LSB];
    assign sync_wr_o = st_r.misc[queue_ctrl_pkg::SYNC_WR_BIT];
    assign sync_rd_o = st_r.misc[queue_ctrl_pkg::SYNC_RD_BIT];
    assign packer_rst_o = st_r.misc[queue_ctrl_pkg::PACKER_RST_BIT];
    assign key_fwd_o = st_r.key_fwd;
    assign timeout_o = st_r.misc[queue_ctrl_pkg::TIMEOUT_MSB:queue_ctrl_pkg::TIMEOUT_LSB];
    assign tex_burst_o = st_r.misc[queue_ctrl_pkg::TEX_BURST_BIT];
    assign fetch_ok_o = st_r.fetch_ok;
endmodule : queue_ctrl_device
`default_nettype wire

/* File: logic/queue_ctrl_host.sv */
// host end: turns single commands into single-cycle register accesses
`timescale 1ns/10ps
`default_nettype none
module queue_ctrl_host (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    queue_ctrl_if.host bus,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic unlock_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o
);
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
        logic unlock;
        logic rd_pend;
        logic [31:0] rdata;
        logic rvalid;
    } host_s;

    host_s st_r;
    host_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // strobes follow wr_i and rd_i each cycle; write wins, so never both at once
        st_nxt.wr = wr_i;
        st_nxt.rd = rd_i && !wr_i;
        st_nxt.addr = addr_i;
        st_nxt.wdata = wdata_i;
        st_nxt.unlock = unlock_i;
        st_nxt.rd_pend = st_r.rd;
        st_nxt.rvalid = st_r.rd_pend;
        if (st_r.rd_pend) begin
            st_nxt.rdata = bus.rdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    assign bus.addr = st_r.addr;
    assign bus.wdata = st_r.wdata;
    assign bus.wr_stb = st_r.wr;
    assign bus.rd_stb = st_r.rd;
    assign bus.unlock = st_r.unlock;
    assign rdata_o = st_r.rdata;
    assign rvalid_o = st_r.rvalid;
endmodule : queue_ctrl_host
`default_nettype wire

/* File: verification/queue_ctrl_properties.sv */
// register port assertions between the host end and the queue control end
`timescale 1ns/10ps
`default_nettype none
module queue_ctrl_checker #(
    parameter logic [7:0] STRAP_VAL = 8'h00
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [queue_ctrl_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic unlock
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    AST_ONE_STB: assert property (!(wr_stb && rd_stb)) else $error("both strobes high");
    AST_STRAP: assert property (rd_stb && addr == queue_ctrl_pkg::OFF_MISC_INIT |=> rdata[7:0] == STRAP_VAL)
        else $error("strap bits wrong");
    AST_MISC_TOP: assert property (rd_stb && addr == queue_ctrl_pkg::OFF_MISC_INIT |=> rdata[31:28] == 4'h0)
        else $error("misc top bits set");
    AST_BUMP_HI: assert property (rd_stb && addr == queue_ctrl_pkg::OFF_BUMP |=> rdata[31:16] == 16'h0000)
        else $error("bump upper bits set");
    AST_HOLE_HI: assert property (rd_stb && addr == queue_ctrl_pkg::OFF_HOLES |=> rdata[31:16] == 16'h0000)
        else $error("holes upper bits set");
    AST_BASE_RSV: assert property (rd_stb && addr == queue_ctrl_pkg::OFF_BASE_END |=>
        (rdata & ~queue_ctrl_pkg::BASE_END_MASK) == 32'h0000_0000) else $error("base reserved bits set");
    AST_BASE_RB: assert property (wr_stb && addr == queue_ctrl_pkg::OFF_BASE_END ##2
        rd_stb && addr == $past(addr, 2) |=> rdata == ($past(wdata, 3) & queue_ctrl_pkg::BASE_END_MASK))
        else $error("base readback wrong");
    AST_MINMAX_RB: assert property (wr_stb && (addr == queue_ctrl_pkg::OFF_MIN_ADDR ||
        addr == queue_ctrl_pkg::OFF_MAX_ADDR) ##2 rd_stb && addr == $past(addr, 2) |=> rdata == $past(wdata, 3))
        else $error("bound readback wrong");
    cover property (wr_stb && unlock && addr == queue_ctrl_pkg::OFF_MISC_INIT);
endmodule : queue_ctrl_checker
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench: host end and queue control end joined by the register port
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [7:0] STRAP = 8'hA5;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] a = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic wr = 1'b0, rd = 1'b0, ul = 1'b0, pmq = 1'b0, ckw = 1'b0, ft = 1'b0, hf = 1'b0, ce = 1'b1;
    logic rv, qen, offs, swr, srd, prst, kfw, tbu, fok;
    logic [4:0] thr;
    logic [6:0] tmo;
    logic [31:0] rdo, got, m;
    int n_errors = 0, checks = 0;
    logic [31:0] pat [3] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hF5A5_5AFF};
    queue_ctrl_if q_if ();
    queue_ctrl_host queue_ctrl_host_inst (.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(ce), .bus(q_if.host),
        .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .unlock_i(ul), .rdata_o(rdo), .rvalid_o(rv));
    queue_ctrl_device queue_ctrl_device_inst (.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(ce), .bus(q_if.device),
        .frame_memory_data_lines_i(STRAP), .primary_mem_queue_en_i(pmq), .color_key_wr_i(ckw), .fetch_take_i(ft),
        .hole_fill_i(hf), .queue_en_o(qen), .offscreen_o(offs), .fetch_thr_o(thr), .sync_wr_o(swr), .sync_rd_o(srd),
        .packer_rst_o(prst), .key_fwd_o(kfw), .timeout_o(tmo), .tex_burst_o(tbu), .fetch_ok_o(fok));
    queue_ctrl_checker #(.STRAP_VAL(STRAP)) chk_inst (.core_clk_i(clk), .rstn_i(rstn), .addr(q_if.addr),
        .wdata(q_if.wdata), .wr_stb(q_if.wr_stb), .rd_stb(q_if.rd_stb), .rdata(q_if.rdata), .unlock(q_if.unlock));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic wreg(input logic [3:0] ad, input logic [31:0] d, input logic u);
        @(posedge clk);
        a <= ad;
        wd <= d;
        ul <= u;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] ad, output logic [31:0] d);
        @(posedge clk);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        for (int i = 0; i < 8 && rv !== 1'b1; i++) begin
            @(negedge clk);
        end
        d = (rv === 1'b1) ? rdo : 32'hDEAD_0BAD;
    endtask : rreg
    // one-cycle fetch take (f high) or hole fill (f low)
    task automatic pulse(input logic f);
        @(posedge clk);
        ft <= f;
        hf <= !f;
        @(posedge clk);
        ft <= 1'b0;
        hf <= 1'b0;
    endtask : pulse
    initial begin
        #20000;
        n_errors++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rreg(i == 8 ? 4'hF : i[3:0], got);
            cmp(got, i == 0 ? {24'h0, STRAP} : 32'h0000_0000);
        end
        // first write is locked and must be dropped
        m = 32'h0000_0000;
        for (int k = 0; k < 3; k++) begin
            wreg(4'h0, pat[k], k != 0);
            if (k != 0) m = pat[k] & queue_ctrl_pkg::MISC_WR_MASK;
            repeat (2) @(negedge clk);
            got = {14'h0, tbu, tmo, prst, srd, swr, thr, offs, qen};
            cmp(got, {14'h0, m[27:20], m[18:11], m[9:8]});
            rreg(4'h0, got);
            cmp(got, m | {24'h0, STRAP});
            if (k == 1) begin
                @(posedge clk);
                ckw <= 1'b1;
                pmq <= 1'b1;
                repeat (3) @(negedge clk);
                cmp({30'h0, kfw, qen}, 32'h0000_0002);
                @(posedge clk);
                ckw <= 1'b0;
                pmq <= 1'b0;
            end
        end
        for (int i = 1; i < 8; i++) begin
            wreg(i[3:0], 32'hFFFF_FFFF, 1'b0);
            rreg(i[3:0], got);
            m = i == 1 ? queue_ctrl_pkg::BASE_END_MASK : (i == 2 || i == 7) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
            cmp(got, m);
        end
        wreg(4'h4, 32'h0000_0100, 1'b0);
        wreg(4'h5, 32'h0000_1000, 1'b0);
        wreg(4'h3, 32'h0000_0100, 1'b0);
        wreg(4'h7, 32'h0000_0000, 1'b0);
        wreg(4'h6, 32'h0000_0002, 1'b0);
        wreg(4'h0, 32'h0000_0500, 1'b1);
        repeat (3) @(negedge clk);
        cmp({31'h0, fok}, 32'h0000_0001);
        // third take finds the count empty and must be ignored
        for (int i = 0; i < 3; i++) begin
            pulse(1'b1);
        end
        pulse(1'b0);
        rreg(4'h3, got);
        cmp(got, 32'h0000_0108);
        rreg(4'h6, got);
        cmp(got, 32'h0000_0000);
        cmp({31'h0, fok}, 32'h0000_0000);
        rreg(4'h7, got);
        cmp(got, 32'h0000_0000);
        wreg(4'h0, 32'h0000_0100, 1'b1);
        pulse(1'b0);
        rreg(4'h7, got);
        cmp(got, 32'h0000_0001);
        rreg(4'h6, got);
        cmp(got, 32'h0000_0001);
        // one take past the upper bound wraps the pointer to the lower bound
        wreg(4'h5, 32'h0000_0108, 1'b0);
        pulse(1'b1);
        rreg(4'h3, got);
        cmp(got, 32'h0000_0100);
        // clock enable low: a hole fill must leave the hole count untouched
        @(posedge clk);
        ce <= 1'b0;
        pulse(1'b0);
        @(posedge clk);
        ce <= 1'b1;
        rreg(4'h7, got);
        cmp(got, 32'h0000_0001);
        // reset in mid-run: the hole count clears and the straps load again
        @(posedge clk);
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        rreg(4'h0, got);
        cmp(got, {24'h0, STRAP});
        rreg(4'h7, got);
        cmp(got, 32'h0000_0000);
        results();
    end
endmodule : testbench
`default_nettype wire
